// ### hw/nipc_pkg.sv
package nipc_pkg;
  localparam int NUM_SRC       = 8;
  localparam int PRIO_W        = 3;
  localparam int SW_W          = 32;
  localparam int SW_BLOCK_BIT  = 5;
  localparam int SW_EXC_BIT    = 6;
  localparam int SW_NMI_BIT    = 7;
  localparam logic [SW_W-1:0] SW_RESET = 32'h20;
  localparam int CTRL_PRIO_LSB = 0;
  localparam int CTRL_MASK_BIT = 6;
  localparam int CTRL_FLAG_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h47;
  localparam logic [PRIO_W-1:0] PRIO_LOWEST = 3'h7;
  localparam int SYNC_INT      = 2;
  localparam int SYNC_EXT      = 4;
  localparam int ACK_CYCLES    = 4;
  localparam int REG_CTRL_BASE = 'h000;
  localparam int REG_STWORD    = 'h040;
  localparam int REG_EPC       = 'h044;
  localparam int REG_EPSW      = 'h048;
  localparam int REG_STATUS    = 'h04c;
  localparam int REG_CMD       = 'h050;
  localparam int REG_EXTSEL    = 'h054;
  localparam int CMD_ENABLE    = 0;
  localparam int CMD_DISABLE   = 1;
  localparam int CMD_RETURN    = 2;
  localparam int CMD_TRAP      = 3;
  localparam int CMD_NMI       = 4;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
  } nipc_wreq_t;
endpackage

// ### hw/nipc_arb.sv
`timescale 1ns/100ps
`default_nettype none
module nipc_arb #(
  parameter int N = nipc_pkg::NUM_SRC
) (
  input  wire logic [N-1:0]                  req,
  input  wire logic [N*nipc_pkg::PRIO_W-1:0] prio,
  output logic                               found,
  output logic [$clog2(N)-1:0]               idx,
  output logic [nipc_pkg::PRIO_W-1:0]        bestPrio
);
  // Lowest number wins; ties go to the lowest source index.
  always_comb begin
    found    = 1'b0;
    idx      = '0;
    bestPrio = nipc_pkg::PRIO_LOWEST;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!found || prio[i*nipc_pkg::PRIO_W +: nipc_pkg::PRIO_W] < bestPrio)) begin
        found    = 1'b1;
        idx      = i[$clog2(N)-1:0];
        bestPrio = prio[i*nipc_pkg::PRIO_W +: nipc_pkg::PRIO_W];
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/nipc_top.sv
`timescale 1ns/100ps
`default_nettype none
module nipc_top #(
  parameter int N = nipc_pkg::NUM_SRC
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic [N-1:0]          srcReq,
  input  wire logic                  nmiReq,
  input  wire logic                  standby,
  input  wire logic                  extBusBusy,
  output logic                       ackPulse,
  output logic [$clog2(N)-1:0]       ackIdx,
  output logic                       fetchKill,
  output logic                       handlerFetch,
  output logic                       awready,
  output logic                       wready,
  output logic                       bvalid,
  output logic [1:0]                 bresp,
  output logic                       arready,
  output logic                       rvalid,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  input  wire logic                  awvalid,
  input  wire logic [31:0]           awaddr,
  input  wire logic                  wvalid,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  bready,
  input  wire logic                  arvalid,
  input  wire logic [31:0]           araddr,
  input  wire logic                  rready
);
  localparam int IW = $clog2(N);
  localparam int PW = nipc_pkg::PRIO_W;

  typedef enum logic [1:0] {ST_RUN, ST_ACK} nipc_phase_t;

  typedef struct packed {
    logic [N-1:0][7:0]  ctrl;
    logic [N-1:0]       extSel;
    logic [N-1:0][2:0]  dly;
    logic [N-1:0]       inSvc;
    logic [31:0]        statWord;
    logic [31:0]        epc;
    logic [31:0]        epsw;
    logic [31:0]        pc;
    logic               nmiSvc;
    logic               noSample;
    nipc_phase_t        phase;
    logic [2:0]         ackCnt;
    logic [IW-1:0]      ackSel;
    logic               awHeld;
    logic [31:0]        awAddr;
    logic               wHeld;
    logic [31:0]        wData;
    logic [3:0]         wStrb;
    logic               bv;
    logic               rv;
    logic [31:0]        rd;
    logic               ackP;
    logic               kill;
    logic               hFetch;
  } nipc_state_t;

  nipc_state_t s_r;
  nipc_state_t s_nxt;

  logic [N-1:0]    ready;
  logic [N*PW-1:0] prioFlat;
  logic            found;
  logic [IW-1:0]   winIdx;
  logic [PW-1:0]   winPrio;
  logic            svcFound;
  logic [IW-1:0]   svcIdx;
  logic [PW-1:0]   svcPrio;

  ////////////////////////////////////////////////////////////////////////////////
  // Request qualification and arbitration.
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gSrc
      // At or past the sync count, so a request blocked for a while is not lost.
      assign ready[g] = s_r.ctrl[g][nipc_pkg::CTRL_FLAG_BIT]
                        && !s_r.ctrl[g][nipc_pkg::CTRL_MASK_BIT]
                        && !s_r.inSvc[g]
                        && (s_r.dly[g] >= (s_r.extSel[g] ? 3'(nipc_pkg::SYNC_EXT)
                                                           : 3'(nipc_pkg::SYNC_INT)));
      assign prioFlat[g*PW +: PW] = s_r.ctrl[g][nipc_pkg::CTRL_PRIO_LSB +: PW];
    end
  endgenerate

  nipc_arb #(.N(N)) uReq (
    .req      (ready),
    .prio     (prioFlat),
    .found    (found),
    .idx      (winIdx),
    .bestPrio (winPrio)
  );

  nipc_arb #(.N(N)) uSvc (
    .req      (s_r.inSvc),
    .prio     (prioFlat),
    .found    (svcFound),
    .idx      (svcIdx),
    .bestPrio (svcPrio)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    logic        doW;
    logic        doR;
    logic [31:0] rsp;
    logic        take;
    int          k;
    s_nxt      = s_r;
    doW        = 1'b0;
    doR        = 1'b0;
    rsp        = 32'h0;
    take       = 1'b0;
    k          = 0;
    s_nxt.ackP = 1'b0;
    s_nxt.kill = 1'b0;
    s_nxt.hFetch = 1'b0;
    s_nxt.noSample = 1'b0;

    // Sync delay counters: count while a request is held, saturating at the external sync count.
    for (int i = 0; i < N; i++) begin
      if (!srcReq[i]) begin
        s_nxt.dly[i] = 3'h0;
      end else if (s_r.dly[i] != 3'(nipc_pkg::SYNC_EXT)) begin
        s_nxt.dly[i] = s_r.dly[i] + 3'h1;
      end
    end

    // Bus channels.
    if (awvalid && !s_r.awHeld) begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = awaddr;
    end
    if (wvalid && !s_r.wHeld) begin
      s_nxt.wHeld = 1'b1;
      s_nxt.wData = wdata;
      s_nxt.wStrb = wstrb;
    end
    if (s_r.bv && bready) begin
      s_nxt.bv = 1'b0;
    end
    if (s_r.rv && rready) begin
      s_nxt.rv = 1'b0;
    end
    doW = s_r.awHeld && s_r.wHeld && !s_r.bv;
    doR = arvalid && !s_r.rv;

    if (doR) begin
      if (araddr[11:0] < 12'(nipc_pkg::REG_CTRL_BASE + 4 * N)) begin
        rsp = {24'h0, s_r.ctrl[araddr[IW+1:2]]};
      end else begin
        case (araddr[11:0])
          12'(nipc_pkg::REG_STWORD): rsp = s_r.statWord;
          12'(nipc_pkg::REG_EPC):    rsp = s_r.epc;
          12'(nipc_pkg::REG_EPSW):   rsp = s_r.epsw;
          12'(nipc_pkg::REG_STATUS): rsp = {15'h0, s_r.nmiSvc, 8'(s_r.inSvc), 8'(s_r.ackSel)};
          12'(nipc_pkg::REG_EXTSEL): rsp = 32'(s_r.extSel);
          default:                   rsp = 32'h0;
        endcase
      end
      s_nxt.rv = 1'b1;
      s_nxt.rd = rsp;
    end

    if (doW) begin
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld  = 1'b0;
      s_nxt.bv     = 1'b1;
      if (s_r.awAddr[11:0] < 12'(nipc_pkg::REG_CTRL_BASE + 4 * N)) begin
        k = int'(s_r.awAddr[IW+1:2]);
        if (s_r.wStrb[0]) begin
          s_nxt.ctrl[k][6:0] = s_r.wData[6:0];
          // Writing 0 to the request flag clears it unless a new request lands now.
          if (!s_r.wData[nipc_pkg::CTRL_FLAG_BIT]) begin
            s_nxt.ctrl[k][nipc_pkg::CTRL_FLAG_BIT] = 1'b0;
          end
        end
        s_nxt.noSample = 1'b1;
      end else begin
        case (s_r.awAddr[11:0])
          12'(nipc_pkg::REG_STWORD): begin
            s_nxt.statWord = s_r.wData;
            s_nxt.noSample = 1'b1;
          end
          12'(nipc_pkg::REG_EPC):    s_nxt.epc = s_r.wData;
          12'(nipc_pkg::REG_EPSW):   s_nxt.epsw = s_r.wData;
          12'(nipc_pkg::REG_EXTSEL): s_nxt.extSel = s_r.wData[N-1:0];
          12'(nipc_pkg::REG_CMD): begin
            // Protection command stores land here too and also block sampling.
            s_nxt.noSample = 1'b1;
            if (s_r.wData[nipc_pkg::CMD_ENABLE]) begin
              s_nxt.statWord[nipc_pkg::SW_BLOCK_BIT] = 1'b0;
            end
            if (s_r.wData[nipc_pkg::CMD_DISABLE]) begin
              s_nxt.statWord[nipc_pkg::SW_BLOCK_BIT] = 1'b1;
            end
            if (s_r.wData[nipc_pkg::CMD_TRAP]) begin
              s_nxt.epc = s_r.pc;
              s_nxt.epsw = s_r.statWord;
              s_nxt.statWord[nipc_pkg::SW_EXC_BIT] = 1'b1;
              s_nxt.statWord[nipc_pkg::SW_BLOCK_BIT] = 1'b1;
            end
            if (s_r.wData[nipc_pkg::CMD_NMI] || nmiReq) begin
              s_nxt.nmiSvc = 1'b1;
            end
            if (s_r.wData[nipc_pkg::CMD_RETURN]) begin
              if (s_r.nmiSvc) begin
                s_nxt.nmiSvc = 1'b0;
              end else if (svcFound) begin
                s_nxt.inSvc[svcIdx] = 1'b0;
              end
              // Acknowledge saved pc and status, so a maskable return reloads them as well,
              // or the block flag would stay set and pending requests would starve.
              if (s_r.statWord[nipc_pkg::SW_EXC_BIT] || (!s_r.nmiSvc && svcFound)) begin
                s_nxt.pc       = s_r.epc;
                s_nxt.statWord = s_r.epsw;
              end
            end
          end
          default: ;
        endcase
      end
    end

    if (nmiReq) begin
      s_nxt.nmiSvc = 1'b1;
    end

    for (int i = 0; i < N; i++) begin
      if (srcReq[i]) begin
        s_nxt.ctrl[i][nipc_pkg::CTRL_FLAG_BIT] = 1'b1;
      end
    end

    // Acknowledge decision; a non-sampling op shields the cycle after it.
    // Equal priority never preempts, so a same-level request waits for the return.
    take = found && (s_r.phase == ST_RUN)
           && !s_r.statWord[nipc_pkg::SW_BLOCK_BIT]
           && !s_r.nmiSvc
           && !s_r.noSample && !s_nxt.noSample
           && !standby && !extBusBusy
           && (!svcFound || winPrio < svcPrio);
    if (take) begin
      s_nxt.phase  = ST_ACK;
      s_nxt.ackCnt = 3'(nipc_pkg::ACK_CYCLES - 1);
      s_nxt.ackSel = winIdx;
      s_nxt.ackP   = 1'b1;
      s_nxt.kill   = 1'b1;
      s_nxt.inSvc[winIdx] = 1'b1;
      s_nxt.ctrl[winIdx][nipc_pkg::CTRL_FLAG_BIT] = srcReq[winIdx];
      s_nxt.epc  = s_r.pc;
      s_nxt.epsw = s_r.statWord;
      s_nxt.statWord[nipc_pkg::SW_BLOCK_BIT] = 1'b1;
    end else if (s_r.phase == ST_ACK) begin
      if (s_r.ackCnt == 3'h0) begin
        s_nxt.phase  = ST_RUN;
        s_nxt.hFetch = 1'b1;
      end else begin
        s_nxt.ackCnt = s_r.ackCnt - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; every source starts masked at level 7.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_r       <= '0;
      s_r.ctrl  <= {N{nipc_pkg::CTRL_RESET}};
      s_r.statWord <= nipc_pkg::SW_RESET;
      s_r.phase <= ST_RUN;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Write readies mirror the hold flops and arready the read response flop, so a held beat refuses the next one.
  assign ackPulse     = s_r.ackP;
  assign ackIdx       = s_r.ackSel;
  assign fetchKill    = s_r.kill;
  assign handlerFetch = s_r.hFetch;
  assign awready      = !s_r.awHeld;
  assign wready       = !s_r.wHeld;
  assign bvalid       = s_r.bv;
  assign bresp        = 2'h0;
  assign arready      = !s_r.rv;
  assign rvalid       = s_r.rv;
  assign rdata        = s_r.rd;
  assign rresp        = 2'h0;
endmodule
`default_nettype wire

// ### test/nipc_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module nipc_src_model #(
  parameter int N = nipc_pkg::NUM_SRC
) (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic [N-1:0]         fire,
  input  wire logic                 ackPulse,
  input  wire logic [$clog2(N)-1:0] ackIdx,
  output logic      [N-1:0]         srcReq
);
  ////////////////////////////////////////////////////////////////////////
  // A source keeps its level up until it is taken, so a held request is never lost.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      srcReq <= '0;
    end else begin
      srcReq <= (srcReq | fire) & ~(ackPulse ? (N'(1) << ackIdx) : N'(0));
    end
  end
endmodule
`default_nettype wire

// ### test/nipc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module nipc_chk #(
  parameter int N = nipc_pkg::NUM_SRC
) (
  input wire logic                 core_clk,
  input wire logic                 reset,
  input wire logic                 standby,
  input wire logic                 extBusBusy,
  input wire logic                 ackPulse,
  input wire logic [$clog2(N)-1:0] ackIdx,
  input wire logic                 fetchKill,
  input wire logic                 handlerFetch,
  input wire logic                 bvalid,
  input wire logic                 bready,
  input wire logic [1:0]           bresp,
  input wire logic                 rvalid,
  input wire logic                 rready,
  input wire logic [31:0]          rdata,
  input wire logic [1:0]           rresp
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  sequence s_ack;
    ackPulse;
  endsequence
  sequence s_fetch4;
    ##4 handlerFetch;
  endsequence
  a_ack_kills_fetch: assert property (s_ack |-> fetchKill)
    else $error("fetched instruction not killed on acknowledge");
  a_fetch_after_ack: assert property (s_ack |-> s_fetch4)
    else $error("handler fetch not four cycles after acknowledge");
  a_fetch_has_cause: assert property (handlerFetch |-> $past(ackPulse, 4))
    else $error("handler fetch without acknowledge four cycles before");
  a_ack_single: assert property (s_ack |=> !ackPulse)
    else $error("acknowledge pulse longer than one cycle");
  a_standby_holds: assert property (standby && $past(standby) |-> !ackPulse)
    else $error("acknowledge during standby");
  a_busbusy_holds: assert property (extBusBusy && $past(extBusBusy) |-> !ackPulse)
    else $error("acknowledge during external bus access");
  a_idx_on_ack: assert property ($changed(ackIdx) |-> ackPulse)
    else $error("source index moved without acknowledge");
  // The response must stand, or a slow master loses it.
  a_bvalid_stands: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped before taken");
  a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before taken");
  a_resp_okay: assert property (bvalid || rvalid |-> bresp == 2'h0 && rresp == 2'h0)
    else $error("bus response not okay");
endmodule
bind nipc_top nipc_chk #(.N(N)) chk_u (.core_clk, .reset, .standby, .extBusBusy, .ackPulse,
  .ackIdx, .fetchKill, .handlerFetch, .bvalid, .bready, .bresp, .rvalid, .rready, .rdata, .rresp);
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int N = nipc_pkg::NUM_SRC;
  logic                 core_clk, reset, nmiReq, standby, extBusBusy, ackPulse, fetchKill;
  logic                 handlerFetch, awready, wready, bvalid, arready, rvalid, rready;
  logic                 awvalid, wvalid, bready, arvalid;
  logic [N-1:0]         srcReq, fire;
  logic [$clog2(N)-1:0] ackIdx, lastIdx;
  logic [1:0]           bresp, rresp;
  logic [31:0]          rdata, awaddr, wdata, araddr, pc, sw, rv;
  logic [3:0]           wstrb;
  int                   bad_count, n_compared, ackCnt, seen, cyc, n;
  nipc_top #(.N(N)) dut_u (.core_clk, .reset, .srcReq, .nmiReq, .standby, .extBusBusy,
    .ackPulse, .ackIdx, .fetchKill, .handlerFetch, .awready, .wready, .bvalid, .bresp,
    .arready, .rvalid, .rdata, .rresp, .awvalid, .awaddr, .wvalid, .wdata, .wstrb, .bready,
    .arvalid, .araddr, .rready);
  nipc_src_model #(.N(N)) src_u (.core_clk, .reset, .fire, .ackPulse, .ackIdx, .srcReq);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Acknowledges are counted at the falling edge so none is missed inside a bus cycle.
  always @(negedge core_clk) if (ackPulse === 1'b1) begin
    ackCnt++;
    lastIdx = ackIdx;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    bit aw, w, b;
    @(posedge core_clk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'h7;
    {aw, w, b} = 3'h0;
    while (!b) begin
      @(negedge core_clk);
      aw = aw | (awvalid & awready);
      w = w | (wvalid & wready);
      b = bvalid & bready;
      @(posedge core_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d);
    bit ar, r;
    @(posedge core_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    {ar, r} = 2'h0;
    while (!r) begin
      @(negedge core_clk);
      ar = ar | (arvalid & arready);
      r = rvalid & rready;
      d = rdata;
      @(posedge core_clk);
      if (ar) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
    end
  endtask
  task automatic cmd(input logic [31:0] d);
    axi_wr(32'h50, d);
  endtask
  task automatic go(input int s);
    @(posedge core_clk) fire <= N'(1) << s;
    @(posedge core_clk) fire <= '0;
  endtask
  task automatic wait_ack(input int i);
    int k;
    k = 0;
    while (ackCnt == seen && k < 40) begin
      @(negedge core_clk);
      k++;
    end
    @(posedge core_clk);
    chk("ackIdx", 32'(i), ackCnt == seen + 1 ? 32'(lastIdx) : 32'hx);
    seen = ackCnt;
  endtask
  task automatic no_ack(input int c);
    repeat (c) @(negedge core_clk);
    chk("ackCount", 32'(seen), 32'(ackCnt));
  endtask
  task automatic lat(input int s, input int lo, input int hi);
    go(s);
    n = 0;
    while (handlerFetch !== 1'b1) begin
      @(negedge core_clk);
      n++;
    end
    chk("latency", 32'h1, 32'(n >= lo && n <= hi));
    seen = ackCnt;
    cmd(32'h4);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int i = 0; i < N; i++) begin
      axi_rd(32'(4 * i), rv);
      chk("ctrlReset", 32'h47, rv);
    end
    axi_rd(32'h40, rv);
    chk("swReset", 32'h20, rv);
    axi_rd(32'h100, rv);
    chk("unmapped", 32'h0, rv);
    axi_wr(32'hc, 32'h5);
    axi_rd(32'hc, rv);
    chk("ctrlPrio", 32'h5, rv);
  endtask
  task automatic t_trap();
    cmd(32'h1);
    axi_rd(32'h40, rv);
    chk("swEnabled", 32'h0, rv);
    cmd(32'h8);
    axi_rd(32'h40, rv);
    chk("swTrap", 32'h60, rv & 32'h60);
    cmd(32'h4);
    axi_rd(32'h40, rv);
    chk("swReturn", 32'h0, rv);
  endtask
  task automatic t_latency();
    axi_wr(32'h0, 32'h3);
    axi_wr(32'h4, 32'h3);
    axi_wr(32'h54, 32'h2);
    lat(0, 4, 10);
    lat(1, 6, 12);
  endtask
  task automatic t_nest();
    axi_wr(32'h8, 32'h5);
    axi_wr(32'hc, 32'h6);
    axi_wr(32'h10, 32'h1);
    seen = ackCnt;
    go(7);
    no_ack(20);
    go(2);
    wait_ack(2);
    go(4);
    go(3);
    no_ack(20);
    axi_rd(32'h44, pc);
    axi_rd(32'h48, sw);
    cmd(32'h1);
    wait_ack(4);
    cmd(32'h4);
    no_ack(20);
    cmd(32'h2);
    axi_wr(32'h48, sw);
    axi_wr(32'h44, pc);
    cmd(32'h4);
    wait_ack(3);
    cmd(32'h4);
  endtask
  task automatic t_nmi();
    axi_wr(32'h14, 32'h2);
    @(posedge core_clk) nmiReq <= 1'b1;
    @(posedge core_clk) nmiReq <= 1'b0;
    cmd(32'h1);
    go(5);
    no_ack(20);
    cmd(32'h4);
    cmd(32'h1);
    wait_ack(5);
    cmd(32'h4);
  endtask
  task automatic t_stall(input bit bus);
    axi_wr(32'h18, 32'h2);
    @(posedge core_clk) {extBusBusy, standby} <= bus ? 2'h2 : 2'h1;
    go(6);
    no_ack(15);
    @(posedge core_clk) {extBusBusy, standby} <= 2'h0;
    wait_ack(6);
    cmd(32'h4);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset, nmiReq, standby, extBusBusy, awvalid, wvalid, bready, arvalid, rready} = 9'h100;
    {fire, awaddr, wdata, araddr, wstrb} = '0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    t_trap();
    t_latency();
    t_nest();
    t_nmi();
    t_stall(1'b0);
    t_stall(1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
